/* File: design/clk_synth_regs_pkg.sv */
// Package for the identification and serial-address register bank.
// Assumes a single system clock; all offsets are byte addresses on the serial port.
package clk_synth_regs_pkg;

    // Block boundaries, last byte address of each range; ID_FIRST and SER_ADDR_OFS are first bytes
    localparam logic [15:0] RSVD_LO_LAST  = 16'h0001;
    localparam logic [15:0] ID_FIRST      = 16'h0002;
    localparam logic [15:0] ID_LAST       = 16'h0005;
    localparam logic [15:0] SER_ADDR_OFS  = 16'h0006;
    localparam logic [15:0] SER_LAST      = 16'h0007;
    localparam logic [15:0] DPLL_LAST     = 16'h002F;
    localparam logic [15:0] GPIO_LAST     = 16'h0038;
    localparam logic [15:0] ODRV_LAST     = 16'h003E;
    localparam logic [15:0] DIVI_LAST     = 16'h004A;
    localparam logic [15:0] RSVD_DIV_LAST = 16'h0056;
    localparam logic [15:0] DIVF_LAST     = 16'h0062;
    localparam logic [15:0] DSRC_LAST     = 16'h0067;
    localparam logic [15:0] APLL_LAST     = 16'h006B;
    localparam logic [15:0] PWR_LAST      = 16'h0070;
    localparam logic [15:0] MON_LAST      = 16'h0078;
    localparam logic [15:0] IEN_LAST      = 16'h0079;
    localparam logic [15:0] FACT_LAST     = 16'h007B;
    localparam logic [15:0] RSVD_MID_LAST = 16'h01FF;
    localparam logic [15:0] ISTAT_LAST    = 16'h0201;
    localparam logic [15:0] RSVD_GP_LAST  = 16'h020B;
    localparam logic [15:0] GPI_LAST      = 16'h020C;
    localparam logic [15:0] GSTAT_LAST    = 16'h0212;

    // Field positions in the bus address byte
    localparam int ADDR_HI_LSB = 2;
    localparam int ADDR_HI_MSB = 6;

    // Factory configuration image; identity values are arbitrary
    localparam logic [3:0]  OTP_REVISION = 4'h1;
    localparam logic [15:0] OTP_PART     = 16'hA5C3;
    localparam logic [10:0] OTP_TAG      = 11'h000;
    localparam logic [4:0]  OTP_ADDR_HI  = 5'h1B;

    // Cycles spent copying the factory image after reset
    localparam logic [7:0]  OTP_LOAD_CYCLES = 8'h04;

    typedef enum logic [4:0] {
        RG_RSVD, RG_ID, RG_SER, RG_DPLL, RG_GPIO, RG_ODRV, RG_DIVI, RG_DIVF, RG_DSRC,
        RG_APLL, RG_PWR, RG_MON, RG_IEN, RG_FACT, RG_ISTAT, RG_GPI, RG_GSTAT
    } region_t;

    typedef enum logic [2:0] {PH_LOAD, PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_RACK} phase_t;

    typedef struct packed {
        logic [3:0]  revision_field;
        logic [15:0] part_code_field;
        logic [10:0] config_tag;
    } id_regs_t;

    typedef struct packed {
        phase_t          phase;
        logic [7:0]      load_cnt;
        logic            ready;
        logic [2:0]      scl_sync;
        logic [2:0]      sda_sync;
        logic [1:0]      sel_low_sync;
        logic [1:0]      sel_high_sync;
        logic [7:0]      shreg;
        logic [3:0]      bitcnt;
        logic [1:0]      byte_idx;
        logic            rd;
        logic            ack_ok;
        logic [15:0]     offset;
        id_regs_t        id;
        logic [4:0]      bus_address_field;
        logic [4:0][7:0] pend;
        logic [4:0]      pend_mask;
        logic            sda_oe;
        logic            sda_level;
    } state_t;

endpackage : clk_synth_regs_pkg

/* File: design/clk_synth_regs.sv */
// Two-wire serial slave with the identification and bus address registers.
// Assumes SCL/SDA and address-select pins are asynchronous and at most 400 kHz.
//
// Behaviour
// - Offsets 0x0002-0x0005 are identification; 0x0000-0x0001 are reserved.
// - Serial interface configuration lives at offsets 0x0006 and 0x0007.
// - Digital PLL control occupies 0x0008 through 0x002F.
// - Pin control at 0x0030-0x0038, output drivers at 0x0039-0x003E.
// - Integer divider at 0x003F-0x004A; 0x004B-0x0056 reserved.
// - Fractional divider settings occupy 0x0057 through 0x0062.
// - Divider source selection occupies 0x0063 through 0x0067.
// - Analog PLL control occupies 0x0068 through 0x006B.
// - Power-down and lock alarm control occupies 0x006C through 0x0070.
// - Monitors 0x0071-0x0078, irq enable 0x0079, factory 0x007A-7B, then reserved.
// - Input status at 0x020C; 0x0202-0x020B reserved.
// - Irq status 0x0200-01, global status 0x020D-0212, 0x0213-03FF reserved.
// - Four bytes pack revision nibble, 16-bit part code, 11-bit tag.
// - Configuration tag holds a factory value and the host may overwrite it.
// - Bus address bits 6:2 are writable, defaulting to 11011b.
// - Bus address bit 1 reads the high address-select pin.
// - Bus address bit 0 reads the low address-select pin.
// - Slave answers only the address formed from register and select pins.
// - After reset the defaults load from the factory configuration memory.
`timescale 1ns/1ps

module clk_synth_regs (
    // Clock and reset
    input  wire logic SYS_CLK_I,
    input  wire logic RST_I,
    // Serial bus, SDA is open drain
    input  wire logic SCL_I,
    input  wire logic SDA_I,
    output logic      SDA_O,
    output logic      SDA_OE_O,
    // Address-select straps
    input  wire logic ADDR_SELECT_PIN_LOW_I,
    input  wire logic ADDR_SELECT_PIN_HIGH_I,
    // Status
    output logic      CFG_READY_O
);
    import clk_synth_regs_pkg::*;

    state_t st;
    state_t next;

    function automatic region_t region_of(input logic [15:0] a);
        region_t r;
        r = RG_RSVD;
        if (a <= RSVD_LO_LAST) r = RG_RSVD;
        else if (a <= ID_LAST) r = RG_ID;
        else if (a <= SER_LAST) r = RG_SER;
        else if (a <= DPLL_LAST) r = RG_DPLL;
        else if (a <= GPIO_LAST) r = RG_GPIO;
        else if (a <= ODRV_LAST) r = RG_ODRV;
        else if (a <= DIVI_LAST) r = RG_DIVI;
        else if (a <= RSVD_DIV_LAST) r = RG_RSVD;
        else if (a <= DIVF_LAST) r = RG_DIVF;
        else if (a <= DSRC_LAST) r = RG_DSRC;
        else if (a <= APLL_LAST) r = RG_APLL;
        else if (a <= PWR_LAST) r = RG_PWR;
        else if (a <= MON_LAST) r = RG_MON;
        else if (a <= IEN_LAST) r = RG_IEN;
        else if (a <= FACT_LAST) r = RG_FACT;
        else if (a <= RSVD_MID_LAST) r = RG_RSVD;
        else if (a <= ISTAT_LAST) r = RG_ISTAT;
        else if (a <= RSVD_GP_LAST) r = RG_RSVD;
        else if (a <= GPI_LAST) r = RG_GPI;
        else if (a <= GSTAT_LAST) r = RG_GSTAT;
        else r = RG_RSVD;
        return r;
    endfunction : region_of

    function automatic logic [31:0] id_word(input id_regs_t id);
        // Revision, part code MSB first, tag
        return {id.revision_field, id.part_code_field, id.config_tag, 1'b0};
    endfunction : id_word

    function automatic logic [7:0] read_byte(input logic [15:0] a, input state_t s);
        logic [31:0] w;
        logic [7:0]  b;
        w = id_word(s.id);
        b = 8'h00;
        // Unimplemented and reserved offsets read as zero
        if (region_of(a) == RG_ID) begin
            case (a[1:0])
                2'h2:    b = w[31:24];
                2'h3:    b = w[23:16];
                2'h0:    b = w[15:8];
                default: b = w[7:0];
            endcase
        end else if (a == SER_ADDR_OFS) begin
            // Bit 1 mirrors the high select pin
            // Bit 0 mirrors the low select pin
            b = {1'b0, s.bus_address_field, s.sel_high_sync[1], s.sel_low_sync[1]};
        end
        return b;
    endfunction : read_byte

    function automatic logic writable(input logic [15:0] a);
        return (region_of(a) == RG_ID) || (a == SER_ADDR_OFS);
    endfunction : writable

    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [6:0] own_addr;
    logic [2:0] widx;
    logic [7:0] next_rd;
    logic [31:0] w_commit;

    // Edges taken from the second and third sync stages only
    assign scl_rise  = st.scl_sync[1] & ~st.scl_sync[2];
    assign scl_fall  = ~st.scl_sync[1] & st.scl_sync[2];
    assign start_det = st.scl_sync[1] & st.scl_sync[2] & st.sda_sync[2] & ~st.sda_sync[1];
    assign stop_det  = st.scl_sync[1] & st.scl_sync[2] & ~st.sda_sync[2] & st.sda_sync[1];
    assign own_addr  = {st.bus_address_field, st.sel_high_sync[1], st.sel_low_sync[1]};
    assign widx      = 3'(st.offset - ID_FIRST);
    assign next_rd   = read_byte(16'(st.offset + 16'h0001), st);

    always_comb begin
        next = st;
        w_commit = id_word(st.id);
        next.scl_sync      = {st.scl_sync[1:0], SCL_I};
        next.sda_sync      = {st.sda_sync[1:0], SDA_I};
        next.sel_low_sync  = {st.sel_low_sync[0], ADDR_SELECT_PIN_LOW_I};
        next.sel_high_sync = {st.sel_high_sync[0], ADDR_SELECT_PIN_HIGH_I};
        next.sda_level     = 1'b0;
        case (st.phase)
            PH_LOAD: begin
                next.sda_oe = 1'b0;
                if (st.load_cnt == OTP_LOAD_CYCLES - 8'h01) begin
                    next.id.revision_field  = OTP_REVISION;
                    next.id.part_code_field = OTP_PART;
                    next.id.config_tag      = OTP_TAG;
                    next.bus_address_field  = OTP_ADDR_HI;
                    next.ready = 1'b1;
                    next.phase = PH_IDLE;
                end else begin
                    next.load_cnt = st.load_cnt + 8'h01;
                end
            end
            PH_IDLE: begin
                next.sda_oe = 1'b0;
            end
            PH_RX: begin
                if (scl_rise) begin
                    next.shreg  = {st.shreg[6:0], st.sda_sync[1]};
                    next.bitcnt = st.bitcnt + 4'h1;
                end else if (scl_fall && st.bitcnt == 4'h8) begin
                    next.phase  = PH_ACK;
                    next.sda_oe = 1'b1;
                    next.bitcnt = 4'h0;
                    if (st.byte_idx != 2'h3) begin
                        next.byte_idx = st.byte_idx + 2'h1;
                    end
                    case (st.byte_idx)
                        2'h0: begin
                            if (st.shreg[7:1] == own_addr) begin
                                next.rd = st.shreg[0];
                            end else begin
                                next.phase  = PH_IDLE;
                                next.sda_oe = 1'b0;
                            end
                        end
                        2'h1: next.offset[15:8] = st.shreg;
                        2'h2: next.offset[7:0]  = st.shreg;
                        default: begin
                            // Writes outside the bank are dropped
                            if (writable(st.offset)) begin
                                next.pend[widx]      = st.shreg;
                                next.pend_mask[widx] = 1'b1;
                            end
                            next.offset = st.offset + 16'h0001;
                        end
                    endcase
                end
            end
            PH_ACK: begin
                if (scl_fall) begin
                    if (st.rd) begin
                        next.phase  = PH_TX;
                        next.shreg  = read_byte(st.offset, st);
                        // Open drain: pull low for a 0, release for a 1
                        next.sda_oe = ~next.shreg[7];
                    end else begin
                        next.phase  = PH_RX;
                        next.sda_oe = 1'b0;
                    end
                end
            end
            PH_TX: begin
                if (scl_fall) begin
                    next.bitcnt = st.bitcnt + 4'h1;
                    if (st.bitcnt == 4'h7) begin
                        next.phase  = PH_RACK;
                        next.sda_oe = 1'b0;
                        next.bitcnt = 4'h0;
                    end else begin
                        next.shreg  = {st.shreg[6:0], 1'b0};
                        next.sda_oe = ~st.shreg[6];
                    end
                end
            end
            PH_RACK: begin
                if (scl_rise) begin
                    next.ack_ok = ~st.sda_sync[1];
                end else if (scl_fall) begin
                    if (st.ack_ok) begin
                        next.phase  = PH_TX;
                        next.offset = st.offset + 16'h0001;
                        next.shreg  = next_rd;
                        next.sda_oe = ~next_rd[7];
                    end else begin
                        next.phase = PH_IDLE;
                    end
                end
            end
            default: begin
                next.phase  = PH_IDLE;
                next.sda_oe = 1'b0;
            end
        endcase
        // Start wins over any byte in flight; repeated start keeps the offset
        if (st.ready && start_det) begin
            next.phase    = PH_RX;
            next.bitcnt   = 4'h0;
            next.byte_idx = 2'h0;
            next.rd       = 1'b0;
            next.sda_oe   = 1'b0;
        end
        // Block write lands all at once on stop, so a partial image is never seen
        if (st.ready && stop_det) begin
            for (int i = 0; i < 4; i++) begin
                if (st.pend_mask[i]) begin
                    w_commit[31 - 8 * i -: 8] = st.pend[i];
                end
            end
            next.id.revision_field  = w_commit[31:28];
            next.id.part_code_field = w_commit[27:12];
            next.id.config_tag      = w_commit[11:1];
            // Only bits 6:2 take the written value
            if (st.pend_mask[4]) begin
                next.bus_address_field = st.pend[4][ADDR_HI_MSB:ADDR_HI_LSB];
            end
            next.pend_mask = 5'h00;
            next.phase     = PH_IDLE;
            next.sda_oe    = 1'b0;
        end
    end

    // PH_LOAD is the zero encoding, so clearing the state restarts the load
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            st <= '0;
        end else begin
            st <= next;
        end
    end

    assign SDA_O       = st.sda_level;
    assign SDA_OE_O    = st.sda_oe;
    assign CFG_READY_O = st.ready;

    // Checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    logic [7:0] slave_byte;
    logic [4:0] pend_addr;
    logic       addr_byte_done;
    assign slave_byte     = read_byte(SER_ADDR_OFS, st);
    assign pend_addr      = st.pend[4][ADDR_HI_MSB:ADDR_HI_LSB];
    assign addr_byte_done = st.phase == PH_RX && scl_fall && st.bitcnt == 4'h8
                            && st.byte_idx == 2'h0 && !start_det && !stop_det;

    sequence s_loading;
        !st.ready [*4];
    endsequence
    sequence s_loaded;
        st.ready && st.bus_address_field == OTP_ADDR_HI && st.id.part_code_field == OTP_PART;
    endsequence

    a_load_then_ready: assert property ($fell(RST_I) |-> s_loading ##1 s_loaded)
        else $error("factory load did not finish after four cycles");
    a_quiet_loading: assert property (!st.ready |-> !SDA_OE_O)
        else $error("serial pin driven before configuration loaded");
    a_pin_low_mirror: assert property (st.ready |-> slave_byte[0] == $past(ADDR_SELECT_PIN_LOW_I, 2))
        else $error("address bit 0 does not follow low select pin");
    a_pin_high_mirror: assert property (st.ready |-> slave_byte[1] == $past(ADDR_SELECT_PIN_HIGH_I, 2))
        else $error("address bit 1 does not follow high select pin");
    a_stop_commit: assert property (stop_det && st.ready && st.pend_mask[4]
                                    |=> st.bus_address_field == $past(pend_addr))
        else $error("bus address not written on stop");
    a_hold_until_stop: assert property (st.ready && !stop_det
                                        |=> $stable(st.id) && $stable(st.bus_address_field))
        else $error("register changed without stop");
    a_foreign_nack: assert property (addr_byte_done && st.shreg[7:1] != own_addr
                                     |=> !SDA_OE_O [*8])
        else $error("acknowledged a foreign bus address");
    a_own_ack: assert property (addr_byte_done && st.shreg[7:1] == own_addr
                                |=> SDA_OE_O && st.phase == PH_ACK)
        else $error("own bus address not acknowledged");
    a_reserved_drop: assert property (st.phase == PH_RX && scl_fall && st.bitcnt == 4'h8
                                      && st.byte_idx == 2'h3 && !writable(st.offset)
                                      && !stop_det |=> $stable(st.pend_mask))
        else $error("write to reserved offset was staged");
    a_tx_bit: assert property (st.phase == PH_TX |-> SDA_OE_O == ~st.shreg[7])
        else $error("transmitted bit differs from shift register");

    // Byte loaded on entry to transmit, before any shift
    // Reserved and undecoded offsets give zero filler
    a_reserved_read: assert property (
        st.phase == PH_TX && $past(st.phase) != PH_TX && !writable(st.offset)
        |-> st.shreg == 8'h00)
        else $error("reserved offset read returned nonzero filler");
    a_id_lead_byte: assert property (
        st.phase == PH_TX && $past(st.phase) != PH_TX && st.offset == ID_FIRST
        |-> st.shreg == {st.id.revision_field, st.id.part_code_field[15:12]})
        else $error("first identification byte is not revision and part code top");
    a_start_restart: assert property (
        st.ready && start_det |=> st.phase == PH_RX && st.byte_idx == 2'h0 && !SDA_OE_O)
        else $error("start condition did not restart address matching");
    a_reset_quiet: assert property (
        @(posedge SYS_CLK_I) disable iff (1'b0) RST_I |=> !st.ready && !SDA_OE_O)
        else $error("ready or serial drive seen during reset");

endmodule : clk_synth_regs

/* File: verification/i2c_host_model.sv */
// Two-wire bus master model: drives SCL and releases or pulls SDA.
// Assumes the caller resolves the open-drain SDA wire with a pull-up.
`timescale 1ns/1ps

module i2c_host_model #(
    parameter int QUARTER = 13
) (
    // Clock
    input  wire logic clk_i,
    // Bus
    input  wire logic sda_line_i,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic quarter();
        repeat (QUARTER) @(posedge clk_i);
    endtask : quarter

    // SDA moves only mid-low, so no false start or stop
    task automatic bit_xfer(input logic b, output logic seen);
        sda_o <= b;
        quarter();
        scl_o <= 1'b1;
        quarter();
        seen = sda_line_i;
        quarter();
        scl_o <= 1'b0;
        quarter();
    endtask : bit_xfer

    // Also serves as repeated start
    task automatic start();
        sda_o <= 1'b1;
        quarter();
        scl_o <= 1'b1;
        quarter();
        sda_o <= 1'b0;
        quarter();
        scl_o <= 1'b0;
        quarter();
    endtask : start

    task automatic stop();
        sda_o <= 1'b0;
        quarter();
        scl_o <= 1'b1;
        quarter();
        sda_o <= 1'b1;
        quarter();
    endtask : stop

    task automatic byte_xfer(input logic [7:0] tx, input logic ack_bit,
                             output logic [7:0] rx, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(tx[i], s);
            rx[i] = s;
        end
        bit_xfer(ack_bit, s);
        acked = ~s;
    endtask : byte_xfer

    task automatic open_at(input logic [6:0] dev, input logic [15:0] ofs, output logic ok);
        logic [7:0] rx;
        logic       a0;
        logic       a1;
        logic       a2;
        start();
        byte_xfer({dev, 1'b0}, 1'b1, rx, a0);
        byte_xfer(ofs[15:8], 1'b1, rx, a1);
        byte_xfer(ofs[7:0], 1'b1, rx, a2);
        ok = a0 & a1 & a2;
    endtask : open_at

    task automatic write_burst(input logic [6:0] dev, input logic [15:0] ofs,
                               input logic [63:0] data, input int n, output logic ok);
        logic [7:0] rx;
        logic       a;
        open_at(dev, ofs, ok);
        for (int i = n - 1; i >= 0; i--) begin
            byte_xfer(data[8 * i +: 8], 1'b1, rx, a);
            ok = ok & a;
        end
        stop();
    endtask : write_burst

    // Master acknowledges every byte but the last
    task automatic read_burst(input logic [6:0] dev, input logic [15:0] ofs, input int n,
                              output logic [63:0] data, output logic ok);
        logic [7:0] rx;
        logic       a;
        open_at(dev, ofs, ok);
        start();
        byte_xfer({dev, 1'b1}, 1'b1, rx, a);
        ok = ok & a;
        data = '0;
        for (int i = 0; i < n; i++) begin
            byte_xfer(8'hFF, i == n - 1, rx, a);
            data = {data[55:0], rx};
        end
        stop();
    endtask : read_burst
endmodule : i2c_host_model

/* File: verification/tb_clk_synth_regs.sv */
// Testbench for the identification and bus address register bank.
// Assumes the two-wire master model and the package's factory image.
`timescale 1ns/1ps

`define CHECK(what, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("Error %s expected %h seen %h", what, exp, got); \
        end \
    end

module tb_clk_synth_regs;
    import clk_synth_regs_pkg::*;

    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [1:0]  pins    = 2'b00;
    logic        scl;
    logic        sda_host;
    logic        sda_drv;
    logic        sda_oe;
    logic        cfg_ready;
    wire         sda_line = sda_host & ~sda_oe;
    int          n_errors  = 0;
    int          cmp_count = 0;
    logic [63:0] rd;
    logic        ok;

    always #25 sys_clk = ~sys_clk;

    clk_synth_regs dut (
        .SYS_CLK_I              (sys_clk),
        .RST_I                  (rst),
        .SCL_I                  (scl),
        .SDA_I                  (sda_line),
        .SDA_O                  (sda_drv),
        .SDA_OE_O               (sda_oe),
        .ADDR_SELECT_PIN_LOW_I  (pins[0]),
        .ADDR_SELECT_PIN_HIGH_I (pins[1]),
        .CFG_READY_O            (cfg_ready)
    );

    i2c_host_model host (
        .clk_i      (sys_clk),
        .sda_line_i (sda_line),
        .scl_o      (scl),
        .sda_o      (sda_host)
    );

    function automatic logic [6:0] dev_of(input logic [4:0] hi);
        return {hi, pins};
    endfunction : dev_of

    function automatic logic [31:0] id_word(input logic [3:0] r, input logic [15:0] p,
                                            input logic [10:0] t);
        return {r, p, t, 1'b0};
    endfunction : id_word

    task automatic expect_read(input logic [6:0] dev, input logic [15:0] ofs, input int n,
                               input logic [63:0] exp, input string what);
        host.read_burst(dev, ofs, n, rd, ok);
        `CHECK("read ack", 1'b1, ok)
        `CHECK(what, exp, rd)
    endtask : expect_read

    task automatic probe(input logic [6:0] dev);
        host.open_at(dev, 16'h0006, ok);
        host.stop();
    endtask : probe

    task automatic t_reset();
        rst <= 1'b1;
        repeat (20) @(posedge sys_clk);
        `CHECK("ready in reset", 1'b0, cfg_ready)
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHECK("ready early", 1'b0, cfg_ready)
        repeat (8) @(posedge sys_clk);
        `CHECK("ready", 1'b1, cfg_ready)
        expect_read(dev_of(OTP_ADDR_HI), 16'h0002, 5, {id_word(OTP_REVISION, OTP_PART,
                    OTP_TAG), 1'b0, OTP_ADDR_HI, pins}, "defaults");
    endtask : t_reset

    task automatic t_pins();
        for (int p = 0; p < 4; p++) begin
            pins <= p[1:0];
            repeat (4) @(posedge sys_clk);
            probe({OTP_ADDR_HI, ~pins});
            `CHECK("foreign address ack", 1'b0, ok)
            expect_read(dev_of(OTP_ADDR_HI), 16'h0006, 1, {1'b0, OTP_ADDR_HI, pins},
                        "strap bits");
            `CHECK("drive level", 1'b0, sda_drv)
        end
    endtask : t_pins

    // Writes into holes are dropped; holes and undecoded blocks read as zero
    task automatic t_reserved();
        logic [15:0] ofs[8] = '{16'h0008, 16'h0030, 16'h0039, 16'h004B,
                                16'h0079, 16'h007C, 16'h020C, 16'h0400};
        host.write_burst(dev_of(OTP_ADDR_HI), 16'h0000, 64'h5A5A, 2, ok);
        host.write_burst(dev_of(OTP_ADDR_HI), 16'h0007, 64'h5A5A, 2, ok);
        expect_read(dev_of(OTP_ADDR_HI), 16'h0000, 7, {16'h0000, id_word(OTP_REVISION,
                    OTP_PART, OTP_TAG), 1'b0, OTP_ADDR_HI, pins}, "low map");
        expect_read(dev_of(OTP_ADDR_HI), 16'h0007, 2, 64'h0, "serial hole");
        foreach (ofs[i]) begin
            expect_read(dev_of(OTP_ADDR_HI), ofs[i], 1, 64'h0, "block");
        end
    endtask : t_reserved

    task automatic t_addr_write();
        pins <= 2'b01;
        repeat (4) @(posedge sys_clk);
        host.write_burst(dev_of(OTP_ADDR_HI), 16'h0006, {1'b0, 5'h09, 2'b00}, 1, ok);
        `CHECK("address write ack", 1'b1, ok)
        probe(dev_of(OTP_ADDR_HI));
        `CHECK("old address ack", 1'b0, ok)
        expect_read(dev_of(5'h09), 16'h0006, 1, 64'h25, "moved address");
        host.write_burst(dev_of(5'h09), 16'h0006, {1'b0, OTP_ADDR_HI, 2'b00}, 1, ok);
        probe(dev_of(OTP_ADDR_HI));
        `CHECK("restored address ack", 1'b1, ok)
    endtask : t_addr_write

    task automatic t_tag_write();
        host.write_burst(dev_of(OTP_ADDR_HI), 16'h0002, id_word(4'h7, 16'h1234, 11'h4D2),
                         4, ok);
        `CHECK("id write ack", 1'b1, ok)
        expect_read(dev_of(OTP_ADDR_HI), 16'h0002, 4, id_word(4'h7, 16'h1234, 11'h4D2),
                    "rewritten id");
    endtask : t_tag_write

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        t_reset();
        t_pins();
        t_reserved();
        t_addr_write();
        t_tag_write();
        // Mid-run reset must restore the factory image
        t_reset();
        tally_and_finish();
    end

    // About 75k cycles expected; limit kept under 100k
    initial begin
        repeat (95000) @(posedge sys_clk);
        n_errors++;
        $display("Error watchdog expected finish seen timeout");
        tally_and_finish();
    end
endmodule : tb_clk_synth_regs
